// >>> hdl/sdf_sinc3_filter.sv
// multichannel sinc3 decimation filter with wake-up and data-ready
`timescale 1ns/100ps
module sdf_sinc3_filter
    import sdf_pkg::*;
#(
    parameter int NCH = SDF_NCH
)
(
    input  wire logic                            MCLK,
    input  wire logic                            SYS_RST,
    input  wire logic                            MODULATOR_CLOCK,
    input  wire logic [NCH-1:0]                  MOD_BITS,
    input  wire logic [SDF_SEL_W-1:0]            DECIM_RATIO_SEL,
    input  wire logic                            RESUME_CONVERSION_CMD,
    input  wire logic                            STANDBY_CMD,
    output logic                                 CONV_DONE_N,
    output logic                                 RESULT_SETTLED,
    output logic                                 CONVERTING,
    output logic [NCH-1:0]                       RESULT_CLIPPED,
    output logic [NCH-1:0][SDF_OUT_W-1:0]        RESULTS
);

    sdf_state_t                          state;
    sdf_ratio_t                          ratio;
    logic                                mod_clk_q;
    logic                                mod_tick;
    logic                                running;
    logic                                wake;
    logic                                sleep;
    logic                                boundary;
    logic [SDF_CNT_W-1:0]                dec_cnt;
    logic                                acc_valid;
    logic                                deliver;
    logic [1:0]                          conv_seq;
    logic [3:0]                          done_cnt;
    logic [NCH-1:0][SDF_OUT_W-1:0]       scaled;
    logic [NCH-1:0]                      clip;
    logic signed [SDF_ACC_W-1:0]         comb [NCH];

    // the modulator clock is synchronous; its rising edge is one tick
    assign mod_tick = MODULATOR_CLOCK && !mod_clk_q;
    assign running  = (state != SDF_STANDBY);
    assign sleep    = running && STANDBY_CMD;
    assign wake     = !running && RESUME_CONVERSION_CMD && !STANDBY_CMD;
    assign boundary = running && mod_tick && (dec_cnt == ratio.last);
    assign deliver  = boundary && acc_valid;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mod_clk_q <= 1'b0;
        end else begin
            mod_clk_q <= MODULATOR_CLOCK;
        end
    end

    // standby and wake-up sequencing
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= SDF_STANDBY;
        end else begin
            unique case (state)
                SDF_STANDBY: begin
                    if (wake) begin
                        state <= SDF_SETTLE;
                    end
                end
                SDF_SETTLE: begin
                    if (sleep) begin
                        state <= SDF_STANDBY;
                    end else if (deliver && conv_seq == SDF_SETTLE_LAST) begin
                        state <= SDF_RUN;
                    end
                end
                SDF_RUN: begin
                    if (sleep) begin
                        state <= SDF_STANDBY;
                    end
                end
            endcase
        end
    end

    // ratio taken once per wake-up so every channel shares it
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ratio <= sdf_ratio_lut('0);
        end else if (wake) begin
            ratio <= sdf_ratio_lut(DECIM_RATIO_SEL);
        end
    end

    // decimation counter, one word every N modulator ticks
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dec_cnt <= SDF_CNT_ZERO;
        end else if (wake || !running) begin
            dec_cnt <= SDF_CNT_ZERO;
        end else if (boundary) begin
            dec_cnt <= SDF_CNT_ZERO;
        end else if (mod_tick) begin
            dec_cnt <= dec_cnt + SDF_CNT_ONE;
        end
    end

    // filter result waits one period before reaching the buffer
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_valid <= 1'b0;
        end else if (wake || !running) begin
            acc_valid <= 1'b0;
        end else if (boundary) begin
            acc_valid <= 1'b1;
        end
    end

    // per channel filters and scalers
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        sdf_sinc3_ch u_ch (
            .clk     (MCLK),
            .rst     (SYS_RST),
            .clear   (wake),
            .tick    (running && mod_tick),
            .dump    (boundary),
            .mod_bit (MOD_BITS[ch]),
            .comb    (comb[ch])
        );

        sdf_scaler u_scale (
            .acc   (comb[ch]),
            .ratio (ratio),
            .word  (scaled[ch]),
            .clip  (clip[ch])
        );
    end

    // output buffer, loaded from the previous period's filter value
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RESULTS        <= {NCH{SDF_OUT_ZERO}};
            RESULT_CLIPPED <= '0;
        end else if (deliver) begin
            RESULTS        <= scaled;
            RESULT_CLIPPED <= clip;
        end
    end

    // delivered results counted until the settled one
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            conv_seq       <= SDF_SEQ_ZERO;
            RESULT_SETTLED <= 1'b0;
        end else if (wake || !running) begin
            conv_seq       <= SDF_SEQ_ZERO;
            RESULT_SETTLED <= 1'b0;
        end else if (deliver) begin
            // unsettled results still delivered
            if (conv_seq == SDF_SETTLE_LAST) begin
                RESULT_SETTLED <= 1'b1;
            end else begin
                conv_seq <= conv_seq + SDF_SEQ_ONE;
            end
        end
    end

    // data-ready low for a fixed time after each delivery, cut short by standby and skipped if standby comes in the same cycle
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CONV_DONE_N <= 1'b1;
            done_cnt    <= SDF_DONE_ZERO;
        end else if (!running || sleep) begin
            CONV_DONE_N <= 1'b1;
            done_cnt    <= SDF_DONE_ZERO;
        end else if (deliver) begin
            CONV_DONE_N <= 1'b0;
            done_cnt    <= SDF_DONE_LOW_CYC;
        end else if (done_cnt == SDF_DONE_ONE) begin
            CONV_DONE_N <= 1'b1;
            done_cnt    <= SDF_DONE_ZERO;
        end else if (done_cnt != SDF_DONE_ZERO) begin
            done_cnt <= done_cnt - SDF_DONE_ONE;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CONVERTING <= 1'b0;
        end else if (wake) begin
            CONVERTING <= 1'b1;
        end else if (sleep) begin
            CONVERTING <= 1'b0;
        end
    end

endmodule

// >>> hdl/sdf_pkg.sv
// shared constants, ratio table and types of the sinc3 decimation filter
package sdf_pkg;

    localparam int SDF_NCH   = 4;
    localparam int SDF_ACC_W = 38;
    localparam int SDF_OUT_W = 24;
    localparam int SDF_MUL_W = 17;
    localparam int SDF_SH_W  = 5;
    localparam int SDF_CNT_W = 12;
    localparam int SDF_SEL_W = 4;
    localparam int SDF_PRD_W = SDF_ACC_W + SDF_MUL_W + 1;

    localparam logic [SDF_ACC_W-1:0] SDF_STEP_POS = 38'h00_0000_0001;
    localparam logic [SDF_ACC_W-1:0] SDF_STEP_NEG = 38'h3f_ffff_ffff;
    localparam logic [SDF_ACC_W-1:0] SDF_ACC_ZERO = 38'h00_0000_0000;
    localparam logic [SDF_OUT_W-1:0] SDF_POS_FS   = 24'h7fffff;
    localparam logic [SDF_OUT_W-1:0] SDF_NEG_FS   = 24'h800000;
    localparam logic [SDF_OUT_W-1:0] SDF_OUT_ZERO = 24'h000000;
    localparam logic [SDF_CNT_W-1:0] SDF_CNT_ZERO = 12'h000;
    localparam logic [SDF_CNT_W-1:0] SDF_CNT_ONE  = 12'h001;

    // multipliers: 2^16 for K=1, 67/64*2^16 and 76*2^10 fold in K
    localparam logic [SDF_MUL_W-1:0] SDF_MUL_P2 = 17'h10000;
    localparam logic [SDF_MUL_W-1:0] SDF_MUL_K5 = 17'h10c00;
    localparam logic [SDF_MUL_W-1:0] SDF_MUL_K3 = 17'h13000;

    // data-ready low time in clock cycles
    localparam logic [3:0] SDF_DONE_LOW_CYC = 4'h4;
    localparam logic [3:0] SDF_DONE_ZERO    = 4'h0;
    localparam logic [3:0] SDF_DONE_ONE     = 4'h1;
    // conversions until settled data
    localparam logic [1:0] SDF_SETTLE_LAST  = 2'h2;
    localparam logic [1:0] SDF_SEQ_ZERO     = 2'h0;
    localparam logic [1:0] SDF_SEQ_ONE      = 2'h1;

    typedef struct packed {
        logic [SDF_CNT_W-1:0] last;
        logic [SDF_MUL_W-1:0] mul;
        logic [SDF_SH_W-1:0]  sh;
    } sdf_ratio_t;

    typedef enum logic [2:0] {
        SDF_STANDBY = 3'b001,
        SDF_SETTLE  = 3'b010,
        SDF_RUN     = 3'b100
    } sdf_state_t;

    function automatic sdf_ratio_t sdf_ratio_lut(
        input logic [SDF_SEL_W-1:0] sel
    );
        sdf_ratio_t r;
        unique case (sel)
            4'h0: r = '{12'hfff, SDF_MUL_P2, 5'h1d};
            4'h1: r = '{12'h7ff, SDF_MUL_P2, 5'h1a};
            4'h2: r = '{12'h3ff, SDF_MUL_P2, 5'h17};
            4'h3: r = '{12'h31f, SDF_MUL_K5, 5'h16};
            4'h4: r = '{12'h2ff, SDF_MUL_K3, 5'h16};
            4'h5: r = '{12'h1ff, SDF_MUL_P2, 5'h14};
            4'h6: r = '{12'h18f, SDF_MUL_K5, 5'h13};
            4'h7: r = '{12'h17f, SDF_MUL_K3, 5'h13};
            4'h8: r = '{12'h0ff, SDF_MUL_P2, 5'h11};
            4'h9: r = '{12'h0c7, SDF_MUL_K5, 5'h10};
            4'ha: r = '{12'h0bf, SDF_MUL_K3, 5'h10};
            4'hb: r = '{12'h07f, SDF_MUL_P2, 5'h0e};
            4'hc: r = '{12'h05f, SDF_MUL_K3, 5'h0d};
            4'hd: r = '{12'h03f, SDF_MUL_P2, 5'h0b};
            4'he: r = '{12'h02f, SDF_MUL_K3, 5'h0a};
            4'hf: r = '{12'h01f, SDF_MUL_P2, 5'h08};
        endcase
        return r;
    endfunction

endpackage

// >>> hdl/sdf_sinc3_ch.sv
// one channel of integrators and decimated differentiators
`timescale 1ns/100ps
module sdf_sinc3_ch
    import sdf_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        clear,
    input  wire logic                        tick,
    input  wire logic                        dump,
    input  wire logic                        mod_bit,
    output logic signed [SDF_ACC_W-1:0]      comb
);

    logic signed [SDF_ACC_W-1:0] int1;
    logic signed [SDF_ACC_W-1:0] int2;
    logic signed [SDF_ACC_W-1:0] int3;
    logic signed [SDF_ACC_W-1:0] dly1;
    logic signed [SDF_ACC_W-1:0] dly2;
    logic signed [SDF_ACC_W-1:0] dly3;
    logic signed [SDF_ACC_W-1:0] step;
    logic signed [SDF_ACC_W-1:0] dif1;
    logic signed [SDF_ACC_W-1:0] dif2;
    logic signed [SDF_ACC_W-1:0] int3_next;

    // bit maps to +1 or -1
    assign step = mod_bit ? SDF_STEP_POS : SDF_STEP_NEG;
    // dump takes the sum with the boundary tick in, full window by result 3
    assign int3_next = int3 + int2;
    assign dif1 = int3_next - dly1;
    assign dif2 = dif1 - dly2;

    // wrap-around integrators, exact once differenced
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int1 <= SDF_ACC_ZERO;
            int2 <= SDF_ACC_ZERO;
            int3 <= SDF_ACC_ZERO;
        end else if (clear) begin
            int1 <= SDF_ACC_ZERO;
            int2 <= SDF_ACC_ZERO;
            int3 <= SDF_ACC_ZERO;
        end else if (tick) begin
            int1 <= int1 + step;
            int2 <= int2 + int1;
            int3 <= int3_next;
        end
    end

    // three differentiators at the output rate, symmetric taps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly1 <= SDF_ACC_ZERO;
            dly2 <= SDF_ACC_ZERO;
            dly3 <= SDF_ACC_ZERO;
            comb <= SDF_ACC_ZERO;
        end else if (clear) begin
            dly1 <= SDF_ACC_ZERO;
            dly2 <= SDF_ACC_ZERO;
            dly3 <= SDF_ACC_ZERO;
            comb <= SDF_ACC_ZERO;
        end else if (dump) begin
            dly1 <= int3_next;
            dly2 <= dif1;
            dly3 <= dif2;
            comb <= dif2 - dly3;
        end
    end

endmodule

// >>> hdl/sdf_scaler.sv
// scales a raw sinc3 sum to the output word with saturation
`timescale 1ns/100ps
module sdf_scaler
    import sdf_pkg::*;
(
    input  wire logic signed [SDF_ACC_W-1:0] acc,
    input  wire sdf_ratio_t                  ratio,
    output logic [SDF_OUT_W-1:0]             word,
    output logic                             clip
);

    logic signed [SDF_PRD_W-1:0]         prod;
    logic signed [SDF_PRD_W-1:0]         shifted;
    logic [SDF_PRD_W-SDF_OUT_W:0]        upper;

    always_comb begin
        // divide by N cubed, K folded into the multiplier
        prod    = acc * $signed({1'b0, ratio.mul});
        shifted = prod >>> ratio.sh;
        upper   = shifted[SDF_PRD_W-1:SDF_OUT_W-1];
        clip    = 1'b0;
        word    = shifted[SDF_OUT_W-1:0];
        // full scale sum is one above the largest code when N is a power of two
        if (!((&upper) || !(|upper))) begin
            clip = 1'b1;
            word = upper[SDF_PRD_W-SDF_OUT_W] ? SDF_NEG_FS : SDF_POS_FS;
        end
    end

endmodule

// >>> tb/sdf_sinc3_props.sv
// port assertions of the sinc3 filter
`timescale 1ns/100ps
module sdf_sinc3_props
    import sdf_pkg::*;
#(
    parameter int NCH = SDF_NCH
)
(
    input wire logic                          MCLK,
    input wire logic                          SYS_RST,
    input wire logic                          MODULATOR_CLOCK,
    input wire logic [NCH-1:0]                MOD_BITS,
    input wire logic [SDF_SEL_W-1:0]          DECIM_RATIO_SEL,
    input wire logic                          RESUME_CONVERSION_CMD,
    input wire logic                          STANDBY_CMD,
    input wire logic                          CONV_DONE_N,
    input wire logic                          RESULT_SETTLED,
    input wire logic                          CONVERTING,
    input wire logic [NCH-1:0]                RESULT_CLIPPED,
    input wire logic [NCH-1:0][SDF_OUT_W-1:0] RESULTS
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_wake;
        RESUME_CONVERSION_CMD && !STANDBY_CMD && !CONVERTING;
    endsequence
    sequence s_pulse;
        (!CONV_DONE_N) [*4] ##1 CONV_DONE_N;
    endsequence
    property p_idle;
        $fell(SYS_RST) |-> CONV_DONE_N && !CONVERTING && !RESULT_SETTLED;
    endproperty
    property p_wake;
        s_wake |=> CONVERTING;
    endproperty
    property p_quiet;
        s_wake |=> CONV_DONE_N [*8];
    endproperty
    property p_stby;
        STANDBY_CMD |=> !CONVERTING && CONV_DONE_N;
    endproperty
    property p_pulse;
        $fell(CONV_DONE_N) |-> s_pulse;
    endproperty
    property p_conv;
        $fell(CONV_DONE_N) |-> $past(CONVERTING);
    endproperty
    property p_hold;
        !$fell(CONV_DONE_N) |-> $stable(RESULTS);
    endproperty
    property p_settle;
        $rose(RESULT_SETTLED) |-> $fell(CONV_DONE_N);
    endproperty
    a_idle: assert property (p_idle) else $error("not idle");
    a_wake: assert property (p_wake) else $error("no wake");
    a_quiet: assert property (p_quiet) else $error("early data");
    a_stby: assert property (p_stby) else $error("no standby");
    a_pulse: assert property (p_pulse) else $error("bad pulse");
    a_conv: assert property (p_conv) else $error("idle data");
    a_hold: assert property (p_hold) else $error("data moved");
    a_settle: assert property (p_settle) else $error("bad settle");
endmodule

bind sdf_sinc3_filter sdf_sinc3_props #(.NCH(NCH)) u_props (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .MODULATOR_CLOCK(MODULATOR_CLOCK),
    .MOD_BITS(MOD_BITS), .DECIM_RATIO_SEL(DECIM_RATIO_SEL),
    .RESUME_CONVERSION_CMD(RESUME_CONVERSION_CMD),
    .STANDBY_CMD(STANDBY_CMD), .CONV_DONE_N(CONV_DONE_N),
    .RESULT_SETTLED(RESULT_SETTLED), .CONVERTING(CONVERTING),
    .RESULT_CLIPPED(RESULT_CLIPPED), .RESULTS(RESULTS));

// >>> tb/sdf_mod_model.sv
// modulator model: two-cycle clock, fixed bit patterns
`timescale 1ns/100ps
module sdf_mod_model
(
    input  wire logic   mclk,
    input  wire logic   rst,
    output logic        mod_clk,
    output logic [3:0]  bits,
    output int unsigned ticks
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mod_clk <= 1'b0;
            bits <= 4'h0;
            ticks <= 0;
        end else if (mod_clk) begin
            mod_clk <= 1'b0;
            ticks <= ticks + 1;
        end else begin
            mod_clk <= 1'b1;
            bits <= {1'b1, ~bits[2], 1'b0, 1'b1};
        end
    end
endmodule

// >>> tb/test_sdf_sinc3_filter.sv
// testbench of the sinc3 decimation filter
`timescale 1ns/100ps
module test_sdf_sinc3_filter
    import sdf_pkg::*;
;
    logic mclk, sys_rst, mod_clk, resume, standby, done_n, settled, conv;
    logic [3:0] mod_bits, sel;
    logic [SDF_NCH-1:0] clipped;
    logic [SDF_NCH-1:0][SDF_OUT_W-1:0] results;
    int unsigned ticks, base;
    int cycles = 0;
    int n_errors = 0;
    int samples_checked = 0;

    sdf_mod_model u_mod (.mclk(mclk), .rst(sys_rst), .mod_clk(mod_clk),
        .bits(mod_bits), .ticks(ticks));
    sdf_sinc3_filter #(.NCH(SDF_NCH)) uut (.MCLK(mclk), .SYS_RST(sys_rst),
        .MODULATOR_CLOCK(mod_clk), .MOD_BITS(mod_bits),
        .DECIM_RATIO_SEL(sel), .RESUME_CONVERSION_CMD(resume),
        .STANDBY_CMD(standby), .CONV_DONE_N(done_n),
        .RESULT_SETTLED(settled), .CONVERTING(conv),
        .RESULT_CLIPPED(clipped), .RESULTS(results));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check({done_n, conv, settled}, 32'h4);
        for (int ch = 0; ch < SDF_NCH; ch++)
            check(results[ch], 32'h0);
        check(clipped, 32'h0);
    endtask

    task automatic wake(input logic [3:0] code);
        sel <= code;
        @(posedge mclk);
        while (mod_clk !== 1'b1) @(posedge mclk);
        resume <= 1'b1;
        @(posedge mclk);
        resume <= 1'b0;
        base = ticks;
    endtask

    task automatic run_ratio(input logic [3:0] code, input int unsigned n,
                             input int kfam);
        int c;
        wake(code);
        @(posedge mclk);
        check(conv, 1'b1);
        for (int k = 1; k <= 3; k++) begin
            for (c = 0; c < 5 * n && done_n !== 1'b0; c++) @(posedge mclk);
            check(ticks - base, (k + 1) * n);
            check(settled, k == 3);
            resume <= (k == 1);
            @(posedge mclk);
            resume <= 1'b0;
            repeat (7) @(posedge mclk);
        end
        check(results[2], 32'h0);
        if (kfam >= 0) begin
            check(results[0], SDF_POS_FS);
            check(results[3], SDF_POS_FS);
            check(results[1], SDF_NEG_FS);
            check(clipped, {1'b1, 1'b0, kfam == 1, 1'b1});
        end else begin
            check(results[0], 32'h7fcad8);
            check(results[1], 32'h803528);
            check(clipped, 32'h0);
        end
        standby <= 1'b1;
        resume <= 1'b1;
        @(posedge mclk);
        standby <= 1'b0;
        resume <= 1'b0;
        @(posedge mclk);
        check({conv, done_n}, 32'h1);
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        resume = 1'b0;
        standby = 1'b0;
        sel = 4'h0;
        do_reset();
        run_ratio(4'hf, 32, 0);
        run_ratio(4'he, 48, 1);
        wake(4'hd);
        repeat (100) @(posedge mclk);
        do_reset();
        run_ratio(4'hd, 64, 0);
        run_ratio(4'ha, 192, 1);
        run_ratio(4'h9, 200, -1);
        run_ratio(4'h3, 800, -1);
        run_ratio(4'h4, 768, 1);
        run_ratio(4'h0, 4096, 0);
        stop_test();
    end
endmodule
